// ---- rtl/adc_scan_sequencer.sv ----
`timescale 1ns/1ps
`include "adc_scan_params.svh"
module adc_scan_sequencer #(
  parameter logic [15:0] CHANNEL_AVAIL = 16'hffff,
  parameter logic [23:0] CONV_CYCLES = `ADC_CONV_CYCLES,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  output logic [23:0] reg_rdata_o,
  output logic data_ready_o,
  // Converter control
  output logic conv_start_o,
  output logic [1:0] power_mode_o,
  output logic [7:0] input_sel_o,
  output logic [2:0] gain_sel_o,
  output logic temp_diodes_o,
  output logic offset_short_o,
  input wire logic [15:0] conv_data_i
);
  generate
    if (CONV_CYCLES == 24'h0 || CONV_CYCLES > 24'h7fffff) begin : g_bad_conv
      $error("CONV_CYCLES must lie between 1 and 0x7fffff");
    end
  endgenerate

  typedef struct packed {
    adc_scan_pkg::seq_state_t st;
    logic [1:0] power;
    logic [1:0] repeat_sel;
    logic [1:0] layout;
    logic [2:0] gain;
    logic az_swap;
    logic [7:0] in_sel;
    logic [15:0] mask;
    logic [2:0] pause_code;
    logic [23:0] interval;
    logic [15:0] trim;
    logic [23:0] cnt;
    logic [3:0] chan;
    logic scanning;
    logic [23:0] push_data;
    logic [23:0] result;
    logic result_valid;
    logic [23:0] rdata;
    logic data_ready;
    logic conv_start;
    logic [1:0] power_mode;
    logic [7:0] sel_out;
    logic [2:0] gain_out;
    logic temp_out;
    logic short_out;
  } seq_regs_t;

  seq_regs_t q;
  seq_regs_t next_q;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [23:0] fifo_out_data;
  logic [4:0] pick_limit;
  logic pick_found;
  logic [3:0] pick_index;
  logic [7:0] pick_sel;
  logic pick_force;
  logic [2:0] pick_gain;
  logic pick_temp;
  logic pick_short;
  logic [15:0] trimmed;
  logic [23:0] conv_len;
  logic [23:0] pause_len;
  logic launch;

  scan_result_fifo #(
    .WIDTH(24),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(q.st == adc_scan_pkg::ST_PUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i(q.push_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  scan_channel_pick u_pick (
    .mask_i(q.mask),
    .limit_i(pick_limit),
    .found_o(pick_found),
    .index_o(pick_index),
    .sel_code_o(pick_sel),
    .force_gain_o(pick_force),
    .gain_code_o(pick_gain),
    .temp_en_o(pick_temp),
    .short_en_o(pick_short)
  );

  // In the push state look below the channel just converted; a launch starts from the top.
  assign launch = (q.st == adc_scan_pkg::ST_INTERVAL && q.cnt == 24'h0) ||
                  (reg_wr_i && reg_addr_i == `ADC_REG_POWER &&
                   reg_wdata_i[`ADC_POWER_LSB +: 2] == `ADC_PWR_CONVERT);
  assign pick_limit = (q.st == adc_scan_pkg::ST_PUSH && !launch) ? {1'b0, q.chan}
                                                                   : 5'h10;
  assign trimmed = conv_data_i + q.trim;
  assign conv_len = q.az_swap ? 24'(CONV_CYCLES << 1) : CONV_CYCLES;
  assign pause_len = (q.pause_code == 3'h0) ? 24'h0 :
                     24'(`ADC_PAUSE_UNIT << (q.pause_code - 3'h1));
  assign fifo_pop = fifo_out_valid && !q.result_valid;

  always_comb begin
    next_q = q;
    next_q.data_ready = 1'b0;
    next_q.conv_start = 1'b0;

    // Result register is loaded from the buffer when empty; reading it frees it.
    if (reg_rd_i && reg_addr_i == `ADC_REG_RESULT) begin
      next_q.result_valid = 1'b0;
    end
    if (fifo_pop) begin
      next_q.result = fifo_out_data;
      next_q.result_valid = 1'b1;
      next_q.data_ready = 1'b1;
    end

    // Sequencer.
    case (q.st)
      adc_scan_pkg::ST_IDLE: begin
      end
      adc_scan_pkg::ST_CONVERT: begin
        next_q.cnt = q.cnt - 24'h1;
        if (q.cnt == 24'h1) begin
          next_q.st = adc_scan_pkg::ST_PUSH;
          if (q.layout == `ADC_LAYOUT_TAGGED) begin
            next_q.push_data = {q.chan, {4{trimmed[15]}}, trimmed};
          end else begin
            next_q.push_data = {{8{trimmed[15]}}, trimmed};
          end
        end
      end
      adc_scan_pkg::ST_PUSH: begin
        // A full buffer stalls the sequencer until the host drains it.
        if (fifo_in_ready) begin
          if (q.scanning && pick_found && q.mask != 16'h0) begin
            next_q.chan = pick_index;
            next_q.sel_out = pick_sel;
            next_q.gain_out = pick_force ? pick_gain : q.gain;
            next_q.temp_out = pick_temp;
            next_q.short_out = pick_short;
            if (pause_len == 24'h0) begin
              next_q.st = adc_scan_pkg::ST_CONVERT;
              next_q.conv_start = 1'b1;
              next_q.cnt = conv_len;
            end else begin
              next_q.st = adc_scan_pkg::ST_PAUSE;
              next_q.cnt = pause_len;
              next_q.power_mode = `ADC_PWR_STANDBY;
            end
          end else if (q.repeat_sel == `ADC_REPEAT_CONT) begin
            next_q.st = adc_scan_pkg::ST_INTERVAL;
            next_q.cnt = q.scanning ? q.interval : 24'h0;
            next_q.power_mode = `ADC_PWR_STANDBY;
          end else begin
            next_q.st = adc_scan_pkg::ST_IDLE;
            next_q.scanning = 1'b0;
            next_q.power = (q.repeat_sel == `ADC_PWR_STANDBY) ? `ADC_PWR_STANDBY
                                                               : `ADC_PWR_SHUTDOWN;
            next_q.power_mode = next_q.power;
          end
        end
      end
      adc_scan_pkg::ST_PAUSE: begin
        next_q.cnt = q.cnt - 24'h1;
        if (q.cnt == 24'h1) begin
          next_q.st = adc_scan_pkg::ST_CONVERT;
          next_q.conv_start = 1'b1;
          next_q.cnt = conv_len;
          next_q.power_mode = `ADC_PWR_CONVERT;
        end
      end
      adc_scan_pkg::ST_INTERVAL: begin
        next_q.cnt = q.cnt - 24'h1;
        if (q.cnt == 24'h0) begin
          next_q.st = adc_scan_pkg::ST_IDLE;
          next_q.power = `ADC_PWR_CONVERT;
        end
      end
      default: begin
        next_q.st = adc_scan_pkg::ST_IDLE;
      end
    endcase

    // Launch a cycle or a single conversion; the interval end relaunches here too.
    if (launch) begin
      next_q.power = `ADC_PWR_CONVERT;
      next_q.power_mode = `ADC_PWR_CONVERT;
      next_q.conv_start = 1'b1;
      next_q.cnt = conv_len;
      next_q.st = adc_scan_pkg::ST_CONVERT;
      if (q.mask != 16'h0) begin
        next_q.scanning = 1'b1;
        next_q.chan = pick_index;
        next_q.sel_out = pick_sel;
        next_q.gain_out = pick_force ? pick_gain : q.gain;
        next_q.temp_out = pick_temp;
        next_q.short_out = pick_short;
      end else begin
        next_q.scanning = 1'b0;
        next_q.chan = 4'h0;
        next_q.sel_out = q.in_sel;
        next_q.gain_out = q.gain;
        next_q.temp_out = 1'b0;
        next_q.short_out = 1'b0;
      end
    end else if (reg_wr_i && reg_addr_i == `ADC_REG_POWER) begin
      // Any other power code aborts the running work, unless the interval ends in that cycle; the relaunch then wins.
      next_q.power = reg_wdata_i[`ADC_POWER_LSB +: 2];
      next_q.power_mode = reg_wdata_i[`ADC_POWER_LSB +: 2];
      next_q.st = adc_scan_pkg::ST_IDLE;
      next_q.scanning = 1'b0;
      next_q.conv_start = 1'b0;
    end

    // Plain register writes; none of these restarts a conversion.
    if (reg_wr_i) begin
      case (reg_addr_i)
        `ADC_REG_GAIN: begin
          next_q.gain = reg_wdata_i[`ADC_GAIN_LSB +: 3];
          next_q.az_swap = reg_wdata_i[`ADC_AZ_SWAP_BIT];
        end
        `ADC_REG_MODE: begin
          next_q.repeat_sel = reg_wdata_i[`ADC_REPEAT_LSB +: 2];
          next_q.layout = reg_wdata_i[`ADC_LAYOUT_LSB +: 2];
        end
        `ADC_REG_INPUT_SEL: begin
          next_q.in_sel = reg_wdata_i[7:0];
        end
        `ADC_REG_SCAN: begin
          next_q.mask = reg_wdata_i[15:0] & CHANNEL_AVAIL;
          next_q.pause_code = reg_wdata_i[`ADC_SCAN_PAUSE_LSB +: 3];
        end
        `ADC_REG_INTERVAL: begin
          next_q.interval = reg_wdata_i;
        end
        `ADC_REG_TRIM: begin
          next_q.trim = reg_wdata_i[15:0];
        end
        default: begin
        end
      endcase
    end

    // Read data appear one cycle after the read strobe.
    if (reg_rd_i) begin
      case (reg_addr_i)
        `ADC_REG_RESULT: next_q.rdata = q.result;
        `ADC_REG_POWER: next_q.rdata = {22'h0, q.power};
        `ADC_REG_GAIN: next_q.rdata = {20'h0, q.az_swap, q.gain};
        `ADC_REG_MODE: next_q.rdata = {20'h0, q.layout, q.repeat_sel};
        `ADC_REG_INPUT_SEL: next_q.rdata = {16'h0, q.in_sel};
        `ADC_REG_SCAN: next_q.rdata = {1'b0, q.pause_code, 4'h0, q.mask};
        `ADC_REG_INTERVAL: next_q.rdata = q.interval;
        `ADC_REG_TRIM: next_q.rdata = {8'h0, q.trim};
        default: next_q.rdata = 24'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.st <= adc_scan_pkg::ST_IDLE;
      q.power <= `ADC_POWER_RST;
      q.power_mode <= `ADC_POWER_RST;
      q.repeat_sel <= `ADC_REPEAT_RST;
      q.layout <= `ADC_LAYOUT_RST;
      q.gain <= `ADC_GAIN_RST;
      q.gain_out <= `ADC_GAIN_RST;
      q.in_sel <= `ADC_INPUT_SEL_RST;
      q.mask <= `ADC_MASK_RST;
      q.pause_code <= `ADC_PAUSE_RST;
      q.interval <= `ADC_INTERVAL_RST;
      q.trim <= `ADC_TRIM_RST;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign data_ready_o = q.data_ready;
  assign conv_start_o = q.conv_start;
  assign power_mode_o = q.power_mode;
  assign input_sel_o = q.sel_out;
  assign gain_sel_o = q.gain_out;
  assign temp_diodes_o = q.temp_out;
  assign offset_short_o = q.short_out;
endmodule // adc_scan_sequencer

// ---- common/adc_scan_params.svh ----
`ifndef ADC_SCAN_PARAMS_SVH
`define ADC_SCAN_PARAMS_SVH

// Register offsets (4-bit register address).
`define ADC_REG_RESULT 4'h0
`define ADC_REG_POWER 4'h1
`define ADC_REG_GAIN 4'h3
`define ADC_REG_MODE 4'h4
`define ADC_REG_INPUT_SEL 4'h6
`define ADC_REG_SCAN 4'h7
`define ADC_REG_INTERVAL 4'h8
`define ADC_REG_TRIM 4'h9

// Field positions.
`define ADC_POWER_LSB 0
`define ADC_GAIN_LSB 0
`define ADC_AZ_SWAP_BIT 3
`define ADC_REPEAT_LSB 0
`define ADC_LAYOUT_LSB 2
`define ADC_SCAN_PAUSE_LSB 20

// Reset values.
`define ADC_POWER_RST 2'h0
`define ADC_REPEAT_RST 2'h0
`define ADC_LAYOUT_RST 2'h0
`define ADC_GAIN_RST 3'h1
`define ADC_INPUT_SEL_RST 8'h01
`define ADC_MASK_RST 16'h0000
`define ADC_PAUSE_RST 3'h0
`define ADC_INTERVAL_RST 24'h000000
`define ADC_TRIM_RST 16'h0000

// Power state and mode codes.
`define ADC_PWR_SHUTDOWN 2'h0
`define ADC_PWR_STANDBY 2'h2
`define ADC_PWR_CONVERT 2'h3
`define ADC_REPEAT_CONT 2'h3
`define ADC_LAYOUT_TAGGED 2'h3

// Gain codes forced on monitor channels.
`define ADC_GAIN_THIRD 3'h0
`define ADC_GAIN_UNITY 3'h1

// Selector codes of the monitor channels.
`define ADC_SEL_OFFSET 8'h88
`define ADC_SEL_COMMON 8'hf8
`define ADC_SEL_SUPPLY 8'h98
`define ADC_SEL_TEMP 8'hde

// Timing counts in clock periods.
`define ADC_PAUSE_UNIT 24'h000008
`define ADC_CONV_CYCLES 24'h000100

`endif

// ---- common/adc_scan_pkg.sv ----
package adc_scan_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_PUSH,
    ST_PAUSE,
    ST_INTERVAL
  } seq_state_t;

endpackage

// ---- rtl/scan_result_fifo.sv ----
`timescale 1ns/1ps
module scan_result_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("scan_result_fifo depth must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] head;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } fifo_regs_t;

  fifo_regs_t q;
  fifo_regs_t next_q;
  logic do_wr;
  logic do_rd;
  logic [AW-1:0] rd_next;

  assign in_ready_o = (q.count != (AW+1)'(DEPTH));
  assign out_valid_o = (q.count != '0);
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;
  assign rd_next = q.rd_ptr + AW'(do_rd);
  assign out_data_o = q.head;

  always_comb begin
    next_q = q;
    if (do_wr) begin
      next_q.mem[q.wr_ptr] = in_data_i;
      next_q.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (do_rd) begin
      next_q.rd_ptr = q.rd_ptr + 1'b1;
    end
    next_q.count = q.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    // The head is taken after the write, so a word entering a draining buffer shows at once.
    next_q.head = next_q.mem[rd_next];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end
endmodule // scan_result_fifo

// ---- rtl/scan_channel_pick.sv ----
`timescale 1ns/1ps
`include "adc_scan_params.svh"
module scan_channel_pick (
  // Query
  input wire logic [15:0] mask_i,
  input wire logic [4:0] limit_i,
  // Answer
  output logic found_o,
  output logic [3:0] index_o,
  output logic [7:0] sel_code_o,
  output logic force_gain_o,
  output logic [2:0] gain_code_o,
  output logic temp_en_o,
  output logic short_en_o
);
  logic [15:0] below;
  logic [3:0] idx [17];
  logic hit [17];

  // Only bits strictly below the limit take part; the highest wins.
  genvar g;
  assign hit[0] = 1'b0;
  assign idx[0] = 4'h0;
  generate
    for (g = 0; g < 16; g++) begin : g_bit
      assign below[g] = mask_i[g] && (5'(g) < limit_i);
      assign hit[g+1] = hit[g] || below[g];
      assign idx[g+1] = below[g] ? 4'(g) : idx[g];
    end
  endgenerate

  assign found_o = hit[16];
  assign index_o = idx[16];

  always_comb begin
    force_gain_o = 1'b0;
    gain_code_o = `ADC_GAIN_UNITY;
    temp_en_o = 1'b0;
    short_en_o = 1'b0;
    case (index_o)
      4'hf: begin
        sel_code_o = `ADC_SEL_OFFSET;
        short_en_o = 1'b1;
      end
      4'he: begin
        sel_code_o = `ADC_SEL_COMMON;
        force_gain_o = 1'b1;
      end
      4'hd: begin
        sel_code_o = `ADC_SEL_SUPPLY;
        force_gain_o = 1'b1;
        gain_code_o = `ADC_GAIN_THIRD;
      end
      4'hc: begin
        sel_code_o = `ADC_SEL_TEMP;
        force_gain_o = 1'b1;
        temp_en_o = 1'b1;
      end
      4'hb, 4'ha, 4'h9, 4'h8: begin
        sel_code_o = {1'b0, index_o[1:0], 1'b0, 1'b0, index_o[1:0], 1'b1};
      end
      default: begin
        sel_code_o = {1'b0, index_o[2:0], 4'h8};
      end
    endcase
  end
endmodule // scan_channel_pick

// ---- verification/adc_scan_checker.sv ----
`timescale 1ns/1ps
module adc_scan_checker #(
  parameter logic [15:0] CHANNEL_AVAIL = 16'hffff
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic [23:0] reg_rdata_o,
  // Converter control
  input wire logic conv_start_o,
  input wire logic [1:0] power_mode_o,
  input wire logic [7:0] input_sel_o,
  input wire logic [2:0] gain_sel_o,
  input wire logic temp_diodes_o,
  input wire logic offset_short_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  logic pwr_wr;
  assign pwr_wr = reg_wr_i && reg_addr_i == 4'h1;

  start_power_a: assert property (conv_start_o |-> power_mode_o == 2'h3)
    else $error("conversion started outside convert mode");
  write_start_a: assert property (pwr_wr && reg_wdata_i[1:0] == 2'h3 && power_mode_o != 2'h3
    |=> conv_start_o && power_mode_o == 2'h3) else $error("power write did not start");
  abort_power_a: assert property (pwr_wr && reg_wdata_i[1:0] != 2'h3
    |=> power_mode_o != 2'h3 && !conv_start_o) else $error("abort did not stop");
  start_gap_a: assert property (conv_start_o |=> !conv_start_o [*3])
    else $error("conversion shorter than its time");
  mux_hold_a: assert property (conv_start_o |=> $stable(input_sel_o) [*3])
    else $error("selector moved within a conversion");
  supply_gain_a: assert property (conv_start_o && input_sel_o == 8'h98
    |-> gain_sel_o == 3'h0) else $error("supply gain not forced");
  common_gain_a: assert property (conv_start_o && input_sel_o == 8'hf8
    |-> gain_sel_o == 3'h1) else $error("common-mode gain not forced");
  temp_gain_a: assert property (temp_diodes_o |-> input_sel_o == 8'hde && gain_sel_o == 3'h1)
    else $error("temperature setup wrong");
  offset_short_a: assert property (offset_short_o |-> input_sel_o == 8'h88)
    else $error("short without offset code");
  mask_avail_a: assert property (reg_rd_i && reg_addr_i == 4'h7
    |=> (reg_rdata_o[15:0] & ~CHANNEL_AVAIL) == 16'h0000) else $error("missing mask bit set");

  cover property (conv_start_o && temp_diodes_o);
  cover property (conv_start_o && offset_short_o);
  cover property (pwr_wr && reg_wdata_i[1:0] == 2'h0 && power_mode_o == 2'h3);
endmodule // adc_scan_checker

bind adc_scan_sequencer adc_scan_checker #(.CHANNEL_AVAIL(CHANNEL_AVAIL)) chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .conv_start_o(conv_start_o), .power_mode_o(power_mode_o), .input_sel_o(input_sel_o),
  .gain_sel_o(gain_sel_o), .temp_diodes_o(temp_diodes_o), .offset_short_o(offset_short_o));

// ---- verification/conv_front_model.sv ----
`timescale 1ns/1ps
module conv_front_model #(
  parameter int WINDOW = 16
) (
  // Clock
  input wire logic clk_sys_i,
  // Control from the sequencer
  input wire logic conv_start_i,
  input wire logic [7:0] input_sel_i,
  input wire logic [2:0] gain_sel_i,
  // Sample to the sequencer
  output logic [15:0] conv_data_o
);
  int left = 0;
  logic [15:0] word = 16'h0000;
  logic [15:0] junk = 16'h5a5a;
  // The code is valid only inside a conversion window; outside it the bus toggles.
  always @(posedge clk_sys_i) begin
    junk <= ~junk;
    if (conv_start_i === 1'b1) begin
      left <= WINDOW;
      word <= {input_sel_i, 5'h00, gain_sel_i};
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  assign conv_data_o = (left > 0) ? word : junk;
endmodule // conv_front_model

// ---- verification/test_adc_scan_sequencer.sv ----
`timescale 1ns/1ps
module test_adc_scan_sequencer;
  localparam logic [15:0] AVAIL = 16'hf30f;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [23:0] reg_wdata_i = 24'h000000;
  logic [23:0] reg_rdata_o;
  logic data_ready_o, conv_start_o, temp_diodes_o, offset_short_o;
  logic [1:0] power_mode_o;
  logic [7:0] input_sel_o;
  logic [2:0] gain_sel_o;
  logic [15:0] conv_data_i;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  int dr_count = 0;
  int st[$];
  logic [23:0] rv;
  int g0, g1;

  adc_scan_sequencer #(.CHANNEL_AVAIL(AVAIL), .CONV_CYCLES(24'h000004), .FIFO_DEPTH(8)) dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .data_ready_o(data_ready_o), .conv_start_o(conv_start_o), .power_mode_o(power_mode_o),
    .input_sel_o(input_sel_o), .gain_sel_o(gain_sel_o), .temp_diodes_o(temp_diodes_o),
    .offset_short_o(offset_short_o), .conv_data_i(conv_data_i));
  conv_front_model #(.WINDOW(16)) front (.clk_sys_i(clk_sys_i), .conv_start_i(conv_start_o),
    .input_sel_i(input_sel_o), .gain_sel_i(gain_sel_o), .conv_data_o(conv_data_i));

  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (conv_start_o === 1'b1) st.push_back(cyc);
    if (data_ready_o === 1'b1) dr_count <= dr_count + 1;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    tick(1);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick(1);
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    tick(1);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    tick(1);
    reg_rd_i = 1'b0;
    rv = reg_rdata_o;
  endtask

  task automatic drain();
    repeat (4) begin
      tick(3);
      rd(4'h0);
    end
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (power_mode_o === 2'h3 && k < 2000) begin
      tick(1);
      k++;
    end
    check({23'h0, k < 2000}, 24'h000001);
  endtask

  // Reads keep the result path free while two conversion starts are awaited.
  task automatic run_starts(output int g);
    int k;
    k = 0;
    while (st.size() < 2 && k < 300) begin
      rd(4'h0);
      k++;
    end
    check({23'h0, st.size() >= 2}, 24'h000001);
    g = (st.size() >= 2) ? st[1] - st[0] : 0;
  endtask

  function automatic logic [7:0] sel_of(input logic [3:0] i);
    case (i)
      4'hf: return 8'h88;
      4'he: return 8'hf8;
      4'hd: return 8'h98;
      4'hc: return 8'hde;
      default: return i[3] ? {1'b0, i[1:0], 2'b00, i[1:0], 1'b1} : {1'b0, i[2:0], 4'h8};
    endcase
  endfunction

  function automatic logic [2:0] gain_of(input logic [3:0] i);
    if (i == 4'hd) return 3'h0;
    if (i == 4'he || i == 4'hc) return 3'h1;
    return 3'h5;
  endfunction

  function automatic logic [23:0] expect_word(input logic [3:0] tag, input logic [7:0] sel,
                                              input logic [2:0] gain);
    logic [15:0] d;
    d = {sel, 5'h00, gain} + 16'h0010;
    return {tag, {4{d[15]}}, d};
  endfunction

  task automatic reset_values();
    check({21'h0, gain_sel_o}, 24'h000001);
    check({8'h00, input_sel_o, 2'h0, power_mode_o, data_ready_o, conv_start_o,
           temp_diodes_o, offset_short_o}, 24'h000000);
    rd(4'h6);
    check(rv, 24'h000001);
    rd(4'h7);
    check(rv, 24'h000000);
    rd(4'h1);
    check(rv, 24'h000000);
    rd(4'h2);
    check(rv, 24'h000000);
  endtask

  task automatic single_channel();
    wr(4'h4, 24'h00000c);
    wr(4'h3, 24'h000005);
    wr(4'h9, 24'h000010);
    wr(4'h6, 24'h000038);
    wr(4'h1, 24'h000003);
    wait_idle();
    check({22'h0, power_mode_o}, 24'h000000);
    tick(6);
    rd(4'h0);
    check(rv, expect_word(4'h0, 8'h38, 3'h5));
  endtask

  task automatic scan_full();
    int d0;
    wr(4'h6, 24'h000055);
    wr(4'h4, 24'h00000e);
    wr(4'h7, 24'h00ffff);
    rd(4'h7);
    check(rv, {8'h00, AVAIL});
    d0 = dr_count;
    wr(4'h1, 24'h000003);
    tick(200);
    for (int i = 15; i >= 0; i--) begin
      if (AVAIL[i]) begin
        rd(4'h0);
        check(rv, expect_word(4'(i), sel_of(4'(i)), gain_of(4'(i))));
        tick(3);
      end
    end
    wait_idle();
    check({22'h0, power_mode_o}, 24'h000002);
    check(24'(dr_count - d0), 24'($countones(AVAIL)));
    rd(4'h6);
    check(rv, 24'h000055);
  endtask

  task automatic pair_gap(input logic [23:0] gw, input logic [23:0] mw, output int g);
    wr(4'h3, gw);
    wr(4'h7, mw);
    st.delete();
    wr(4'h1, 24'h000003);
    run_starts(g);
    wait_idle();
    drain();
  endtask

  task automatic scan_pause();
    wr(4'h4, 24'h00000c);
    pair_gap(24'h000005, 24'h000003, g0);
    pair_gap(24'h000005, 24'h100003, g1);
    check(24'(g1 - g0), 24'h000008);
    pair_gap(24'h000005, 24'h200003, g1);
    check(24'(g1 - g0), 24'h000010);
    pair_gap(24'h00000d, 24'h000003, g1);
    check(24'(g1 - g0), 24'h000004);
  endtask

  task automatic rep_gap(input logic [23:0] iv, input logic poke, output int g);
    wr(4'h8, iv);
    st.delete();
    wr(4'h1, 24'h000003);
    if (poke) wr(4'h4, 24'h00000f);
    run_starts(g);
    rd(4'h1);
    check(rv, 24'h000003);
    wr(4'h1, 24'h000000);
    check({22'h0, power_mode_o}, 24'h000000);
    drain();
  endtask

  task automatic repeat_interval();
    wr(4'h4, 24'h00000f);
    wr(4'h3, 24'h000005);
    wr(4'h7, 24'h000100);
    rep_gap(24'h00000a, 1'b0, g0);
    rep_gap(24'h000014, 1'b0, g1);
    check(24'(g1 - g0), 24'h00000a);
    rep_gap(24'h00000a, 1'b1, g1);
    check(24'(g1), 24'(g0));
  endtask

  // Continuous scanning is stopped by changing repeat select just after a data ready.
  task automatic stop_after_ready();
    int k;
    k = 0;
    st.delete();
    wr(4'h1, 24'h000003);
    while (data_ready_o !== 1'b1 && k < 100) begin
      tick(1);
      k++;
    end
    wr(4'h4, 24'h00000e);
    tick(60);
    check(24'(st.size()), 24'h000002);
    rd(4'h1);
    check(rv, 24'h000002);
    drain();
  endtask

  initial begin
    repeat (12) @(posedge clk_sys_i);
    #1;
    reset_n_i = 1'b1;
    reset_values();
    single_channel();
    scan_full();
    scan_pause();
    repeat_interval();
    stop_after_ready();
    final_report();
  end

  initial begin
    #500000;
    mismatches++;
    final_report();
  end
endmodule // test_adc_scan_sequencer
